// ### rtl/dee_consts.vh
// Purpose: shared constants of the data eeprom unlock and control block
// Assumes: 100 MHz system clock, Avalon-MM slave with 32-bit data
// Notes: byte offsets, field positions, reset values and timing counts
// Operation
// - array sits at top of program memory
// - large variant holds 256 words below top
// - small variant 128 words, smallest has none
// - sixteen-bit words, each read and written alone
// - operations run without stalling the bus
// - control, key and address registers steer operations
// - upper byte start and flag, lower selects op
// - key register write-only, guards against stray writes
// - correct key opens one-cycle control write window
// - start bit set in window begins operation
`ifndef DEE_CONSTS_VH
`define DEE_CONSTS_VH

// register byte offsets
`define DEE_OFS_CTRL 5'h00
`define DEE_OFS_KEY 5'h04
`define DEE_OFS_ADDR 5'h08
`define DEE_OFS_DATA 5'h0c
`define DEE_OFS_ISTAT 5'h10
`define DEE_OFS_IMASK 5'h14

// control register fields
`define DEE_CTRL_START 15
`define DEE_CTRL_ERR 13
`define DEE_CTRL_OP_HI 7
`define DEE_CTRL_RST 16'h0000
`define DEE_OP_RST 8'h00
`define DEE_OP_PROG 8'h01
`define DEE_OP_ERASE 8'h02
`define DEE_ERASED 16'hffff

// unlock key values
`define DEE_KEY_FIRST 8'h55
`define DEE_KEY_SECOND 8'haa

// program memory map
`define DEE_TOP_ADDR 24'h7fffff
`define DEE_BASE_LARGE 24'h7ffe00
`define DEE_BASE_SMALL 24'h7fff00
`define DEE_AW 8
`define DEE_WORDS 256

// variant select codes
`define DEE_VAR_NONE 2'h0
`define DEE_VAR_SMALL 2'h1
`define DEE_VAR_LARGE 2'h2

// interrupt status bits
`define DEE_IRQ_N 3
`define DEE_IRQ_DONE 0
`define DEE_IRQ_ERR 1
`define DEE_IRQ_KEYF 2

// operation time
`define DEE_CLK_NS 10
`define DEE_OP_TIME_NS 4000
`define DEE_OP_CYC (`DEE_OP_TIME_NS / `DEE_CLK_NS)
`define DEE_TMR_W 9

`endif

// ### rtl/dee_array.v
// Purpose: 256 x 16 storage of the data eeprom words
// Assumes: one write port, one read port, registered read data
// Notes: read data appear one clock after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"

module dee_array
(
  // clock
  input wire clk_sys_i,
  // write port
  input wire wr_en_i,
  input wire [`DEE_AW-1:0] wr_idx_i,
  input wire [15:0] wr_data_i,
  // read port
  input wire rd_en_i,
  input wire [`DEE_AW-1:0] rd_idx_i,
  output reg [15:0] rd_data_o
);

  reg [15:0] mem_r [0:`DEE_WORDS-1];

  always @(posedge clk_sys_i)
  begin
    if (wr_en_i)
      mem_r[wr_idx_i] <= wr_data_i;
    if (rd_en_i)
      rd_data_o <= mem_r[rd_idx_i];
  end

endmodule // dee_array
`default_nettype wire

// ### rtl/dee_op_timer.v
// Purpose: times one program or erase cycle
// Assumes: start is a one-cycle pulse while idle
// Notes: done is a one-cycle pulse after the full cycle count
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"

module dee_op_timer
(
  // clock and reset
  input wire clk_sys_i,
  input wire rst_b_i,
  // control
  input wire start_i,
  output reg done_o
);

  localparam integer LAST_I = `DEE_OP_CYC - 1;
  localparam [`DEE_TMR_W-1:0] LAST = LAST_I[`DEE_TMR_W-1:0];

  reg [`DEE_TMR_W-1:0] cnt_r;
  reg run_r;

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= {`DEE_TMR_W{1'b0}};
      run_r <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        cnt_r <= {`DEE_TMR_W{1'b0}};
        run_r <= 1'b1;
      end
      else if (run_r)
      begin
        if (cnt_r == LAST)
        begin
          run_r <= 1'b0;
          done_o <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule // dee_op_timer
`default_nettype wire

// ### rtl/dee_ctrl.v
// Purpose: data eeprom unlock, operation control and register slave
// Assumes: Avalon-MM master, one instruction cycle is one clock
// Notes: writes answer at once, reads take three cycles
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"

module dee_ctrl
(
  // clock and reset
  input wire clk_sys_i,
  input wire rst_b_i,
  // avalon-mm slave
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // device variant
  input wire [1:0] variant_i,
  // status
  output wire busy_o,
  output wire irq_o
);

  //////////////////////////////////////////////////////////////////////
  // state codes

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  //////////////////////////////////////////////////////////////////////
  // declarations

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg start_r;
  reg err_r;
  reg [7:0] op_r;
  reg [23:0] tgt_addr_r;
  reg [15:0] wdata_r;
  reg key_half_r;
  reg unlock_r;
  reg [`DEE_IRQ_N-1:0] istat_r;
  reg [`DEE_IRQ_N-1:0] imask_r;
  reg [1:0] rd_ph_r;
  reg [7:0] run_op_r;
  reg [`DEE_AW-1:0] run_idx_r;
  reg [15:0] run_data_r;
  reg run_bad_r;
  reg [23:0] base_addr;
  reg addr_ok;
  reg op_ok;
  wire wr_acc;
  wire sel_ctrl;
  wire sel_key;
  wire sel_addr;
  wire sel_data;
  wire sel_istat;
  wire sel_imask;
  wire key_wr;
  wire key_first;
  wire key_second;
  wire start_req;
  wire op_start;
  wire tmr_done;
  wire finish;
  wire commit;
  wire [15:0] mem_rd;
  wire [15:0] commit_data;
  wire [`DEE_IRQ_N-1:0] ev_set;
  wire [15:0] ctrl_view;

  //////////////////////////////////////////////////////////////////////
  // bus decode

  assign sel_ctrl = (avs_address_i == `DEE_OFS_CTRL);
  assign sel_key = (avs_address_i == `DEE_OFS_KEY);
  assign sel_addr = (avs_address_i == `DEE_OFS_ADDR);
  assign sel_data = (avs_address_i == `DEE_OFS_DATA);
  assign sel_istat = (avs_address_i == `DEE_OFS_ISTAT);
  assign sel_imask = (avs_address_i == `DEE_OFS_IMASK);

  // writes are taken in the cycle they appear
  assign wr_acc = avs_write_i;
  // reads stall until the registered data stand
  assign avs_waitrequest_o = avs_read_i && (rd_ph_r != 2'h2);

  //////////////////////////////////////////////////////////////////////
  // unlock key sequence

  assign key_wr = wr_acc && sel_key && avs_byteenable_i[0];
  assign key_first = key_wr && (avs_writedata_i[7:0] == `DEE_KEY_FIRST);
  assign key_second = key_wr && key_half_r
    && (avs_writedata_i[7:0] == `DEE_KEY_SECOND);

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      key_half_r <= 1'b0;
      unlock_r <= 1'b0;
    end
    else
    begin
      // any other write breaks a half-done sequence
      if (key_first)
        key_half_r <= 1'b1;
      else if (wr_acc)
        key_half_r <= 1'b0;
      // window lasts the single cycle after the second key
      unlock_r <= key_second;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // operation control register

  assign start_req = wr_acc && sel_ctrl && avs_byteenable_i[1]
    && avs_writedata_i[`DEE_CTRL_START];
  // start only counts inside the window and while idle
  assign op_start = start_req && unlock_r && !start_r;

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      op_r <= `DEE_OP_RST;
      err_r <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      if (wr_acc && sel_ctrl && avs_byteenable_i[0] && !start_r)
        op_r <= avs_writedata_i[`DEE_CTRL_OP_HI:0];
      if (op_start)
        start_r <= 1'b1;
      else if (finish)
        start_r <= 1'b0;
      // completion flag wins over a software clear
      if (finish)
        err_r <= run_bad_r;
      else if (wr_acc && sel_ctrl && avs_byteenable_i[1]
        && !avs_writedata_i[`DEE_CTRL_ERR])
        err_r <= 1'b0;
    end
  end

  assign ctrl_view = {start_r, 1'b0, err_r, 5'h00, op_r};

  //////////////////////////////////////////////////////////////////////
  // address and data registers

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tgt_addr_r <= `DEE_BASE_LARGE;
      wdata_r <= 16'h0000;
    end
    else if (wr_acc)
    begin
      if (sel_addr)
      begin
        if (avs_byteenable_i[0])
          tgt_addr_r[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1])
          tgt_addr_r[15:8] <= avs_writedata_i[15:8];
        if (avs_byteenable_i[2])
          tgt_addr_r[23:16] <= avs_writedata_i[23:16];
      end
      if (sel_data)
      begin
        if (avs_byteenable_i[0])
          wdata_r[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1])
          wdata_r[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // address range and operation checks

  always @*
  begin
    base_addr = `DEE_BASE_LARGE;
    addr_ok = 1'b0;
    case (variant_i)
      `DEE_VAR_LARGE:
      begin
        base_addr = `DEE_BASE_LARGE;
        addr_ok = 1'b1;
      end
      `DEE_VAR_SMALL:
      begin
        base_addr = `DEE_BASE_SMALL;
        addr_ok = 1'b1;
      end
      default:
      begin
        base_addr = `DEE_BASE_LARGE;
        addr_ok = 1'b0;
      end
    endcase
    // words sit on even addresses up to the top of program memory
    if (tgt_addr_r < base_addr || tgt_addr_r > `DEE_TOP_ADDR
      || tgt_addr_r[0])
      addr_ok = 1'b0;
    op_ok = (op_r == `DEE_OP_PROG) || (op_r == `DEE_OP_ERASE);
  end

  //////////////////////////////////////////////////////////////////////
  // operation sequencer

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      run_op_r <= 8'h00;
      run_idx_r <= {`DEE_AW{1'b0}};
      run_data_r <= 16'h0000;
      run_bad_r <= 1'b0;
    end
    else if (op_start)
    begin
      // operands are frozen so later bus writes cannot disturb them
      run_op_r <= op_r;
      run_idx_r <= tgt_addr_r[`DEE_AW:1];
      run_data_r <= wdata_r;
      run_bad_r <= !(addr_ok && op_ok);
    end
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (op_start)
          state_nxt = ST_RUN;
      ST_RUN:
        if (tmr_done || run_bad_r)
          state_nxt = ST_DONE;
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  assign finish = (state_r == ST_DONE);
  assign commit = finish && !run_bad_r;
  assign commit_data = (run_op_r == `DEE_OP_ERASE) ? `DEE_ERASED : run_data_r;
  assign busy_o = start_r;

  dee_op_timer u_timer
  (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .start_i(op_start),
    .done_o(tmr_done)
  );

  //////////////////////////////////////////////////////////////////////
  // storage array

  dee_array u_array
  (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(commit),
    .wr_idx_i(run_idx_r),
    .wr_data_i(commit_data),
    .rd_en_i(rd_ph_r == 2'h0),
    .rd_idx_i(tgt_addr_r[`DEE_AW:1]),
    .rd_data_o(mem_rd)
  );

  //////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  assign ev_set[`DEE_IRQ_DONE] = commit;
  assign ev_set[`DEE_IRQ_ERR] = finish && run_bad_r;
  // any key write other than a valid first or second key, or a start outside the window
  assign ev_set[`DEE_IRQ_KEYF] = (key_wr && !key_first && !key_second)
    || (start_req && !unlock_r);

  genvar gi;
  generate
    for (gi = 0; gi < `DEE_IRQ_N; gi = gi + 1)
    begin : g_istat
      always @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          istat_r[gi] <= 1'b0;
        else if (ev_set[gi])
          istat_r[gi] <= 1'b1;
        else if (wr_acc && sel_istat && avs_byteenable_i[0]
          && avs_writedata_i[gi])
          istat_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      imask_r <= {`DEE_IRQ_N{1'b0}};
    else if (wr_acc && sel_imask && avs_byteenable_i[0])
      imask_r <= avs_writedata_i[`DEE_IRQ_N-1:0];
  end

  assign irq_o = |(istat_r & imask_r);

  //////////////////////////////////////////////////////////////////////
  // read path

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_ph_r <= 2'h0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (!avs_read_i || rd_ph_r == 2'h2)
      rd_ph_r <= 2'h0;
    else if (rd_ph_r == 2'h0)
      rd_ph_r <= 2'h1;
    else
    begin
      rd_ph_r <= 2'h2;
      case (avs_address_i)
        `DEE_OFS_CTRL: avs_readdata_o <= {16'h0000, ctrl_view};
        `DEE_OFS_ADDR: avs_readdata_o <= {8'h00, tgt_addr_r};
        `DEE_OFS_DATA: avs_readdata_o <= {16'h0000, mem_rd};
        `DEE_OFS_ISTAT: avs_readdata_o <= {29'h0, istat_r};
        `DEE_OFS_IMASK: avs_readdata_o <= {29'h0, imask_r};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // dee_ctrl
`default_nettype wire

// ### tb/dee_ctrl_properties.sv
// Purpose: port assertions of dee_ctrl
// Assumes: one clock, async active-low reset
// Notes: bound onto dee_ctrl after the module
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"
module dee_ctrl_properties
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // bus
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // status
  input wire logic busy_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  logic key_a;
  logic key_b;
  logic go_w;
  assign key_a = avs_write_i && avs_address_i == `DEE_OFS_KEY
    && avs_writedata_i[7:0] == `DEE_KEY_FIRST;
  assign key_b = avs_write_i && avs_address_i == `DEE_OFS_KEY
    && avs_writedata_i[7:0] == `DEE_KEY_SECOND;
  assign go_w = avs_write_i && avs_address_i == `DEE_OFS_CTRL
    && avs_writedata_i[`DEE_CTRL_START];
  //////////////////////////////////////////////////////////////////
  sequence unlock_seq;
    !busy_o && key_a ##1 key_b ##1 go_w;
  endsequence
  sequence late_seq;
    !busy_o && key_b ##1 !avs_write_i ##1 go_w;
  endsequence
  sequence rd_wait_seq;
    avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  //////////////////////////////////////////////////////////////////
  chk_wr_nowait: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write was made to wait");
  chk_rd_wait: assert property ($rose(avs_read_i) |-> rd_wait_seq)
    else $error("read wait cycles wrong");
  chk_rd_hold: assert property
    ((avs_read_i && !avs_waitrequest_o ##1 !avs_read_i) |-> $stable(avs_readdata_o))
    else $error("read data moved");
  chk_unlock_go: assert property (unlock_seq |=> busy_o)
    else $error("unlocked start ignored");
  chk_start_gated: assert property
    ($rose(busy_o) |-> $past(go_w) && $past(key_b, 2) && $past(key_a, 3))
    else $error("start without unlock");
  chk_late_start: assert property (late_seq |=> !busy_o)
    else $error("late start accepted");
  chk_busy_end: assert property ($rose(busy_o) |-> ##[1:420] !busy_o)
    else $error("busy never cleared");
  chk_reset_idle: assert property ($rose(rst_b_i) |-> !busy_o && !irq_o)
    else $error("not idle after reset");
endmodule // dee_ctrl_properties

bind dee_ctrl dee_ctrl_properties dee_ctrl_properties_i
(
  .clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .busy_o(busy_o),
  .irq_o(irq_o)
);
`default_nettype wire

// ### tb/dee_ctrl_test.sv
// Purpose: self-checking bench of dee_ctrl
// Assumes: avalon-mm master tasks, 100 MHz clock
// Notes: one operation takes about 400 cycles
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"
module dee_ctrl_test;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [1:0] variant = `DEE_VAR_LARGE;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wreq;
  logic busy;
  logic irq;
  int n_fail = 0;
  int check_count = 0;
  int n;
  dee_ctrl dee_ctrl_i
  (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .avs_address_i(adr),
    .avs_read_i(rd_s),
    .avs_write_i(wr_s),
    .avs_writedata_i(wdat),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq),
    .variant_i(variant),
    .busy_o(busy),
    .irq_o(irq)
  );
  always #5 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    rd_s <= 1'b0;
    wr_s <= 1'b1;
    adr <= a;
    wdat <= d;
    // waitrequest is looked at mid-cycle, where it has settled
    @(negedge clk_sys_i);
    while (wreq !== 1'b0)
      @(negedge clk_sys_i);
    @(posedge clk_sys_i);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input string what);
    logic [31:0] got;
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    adr <= a;
    @(negedge clk_sys_i);
    while (wreq !== 1'b0)
      @(negedge clk_sys_i);
    // read data stand unchanged through the edge that ends the read
    got = rdat;
    @(posedge clk_sys_i);
    check(what, got, e);
    rd_s <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic idle;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic run(input logic [31:0] a, input logic [15:0] d, input logic [7:0] op);
    wr(`DEE_OFS_ADDR, a);
    wr(`DEE_OFS_DATA, {16'h0, d});
    wr(`DEE_OFS_CTRL, {24'h0, op});
    wr(`DEE_OFS_KEY, 32'h55);
    wr(`DEE_OFS_KEY, 32'haa);
    wr(`DEE_OFS_CTRL, {16'h0, 8'h80, op});
    idle;
    check("busy_go", busy, 32'h1);
  endtask
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (busy === 1'b1 && cnt < 600)
    begin
      @(negedge clk_sys_i);
      cnt++;
    end
    @(posedge clk_sys_i);
    check("busy_end", busy, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    rc(`DEE_OFS_CTRL, 32'h0, "ctrl_rst");
    rc(`DEE_OFS_KEY, 32'h0, "key_rd");
    rc(`DEE_OFS_ADDR, 32'h7ffe00, "addr_rst");
    rc(5'h1c, 32'h0, "unmapped");
    check("irq_rst", irq, 32'h0);
    $display("reset test done");
    // program the top word, bus stays live meanwhile
    wr(`DEE_OFS_IMASK, 32'h7);
    run(32'h7ffffe, 16'h1234, `DEE_OP_PROG);
    rc(`DEE_OFS_CTRL, 32'h8001, "ctrl_run");
    wait_idle(n);
    check("op_long", n >= 390, 32'h1);
    rc(`DEE_OFS_ISTAT, 32'h1, "istat_ok");
    check("irq_ok", irq, 32'h1);
    rc(`DEE_OFS_DATA, 32'h1234, "data_prog");
    rc(`DEE_OFS_CTRL, 32'h0001, "ctrl_end");
    wr(`DEE_OFS_ISTAT, 32'h1);
    idle;
    check("irq_clr", irq, 32'h0);
    run(32'h7ffffe, 16'h5a5a, `DEE_OP_ERASE);
    wait_idle(n);
    rc(`DEE_OFS_DATA, 32'hffff, "data_erase");
    $display("program erase test done");
    // refused starts: gap, reversed keys, stray write between keys
    wr(`DEE_OFS_KEY, 32'h55);
    wr(`DEE_OFS_KEY, 32'haa);
    idle;
    wr(`DEE_OFS_CTRL, 32'h8001);
    idle;
    check("busy_gap", busy, 32'h0);
    wr(`DEE_OFS_KEY, 32'haa);
    wr(`DEE_OFS_KEY, 32'h55);
    wr(`DEE_OFS_CTRL, 32'h8001);
    idle;
    check("busy_rev", busy, 32'h0);
    wr(`DEE_OFS_KEY, 32'h55);
    wr(`DEE_OFS_DATA, 32'h0);
    wr(`DEE_OFS_KEY, 32'haa);
    wr(`DEE_OFS_CTRL, 32'h8001);
    idle;
    check("busy_stray", busy, 32'h0);
    rc(`DEE_OFS_ISTAT, 32'h5, "istat_key");
    rc(`DEE_OFS_DATA, 32'hffff, "data_kept");
    wr(`DEE_OFS_ISTAT, 32'h7);
    $display("refusal test done");
    // small and absent arrays
    variant <= `DEE_VAR_SMALL;
    run(32'h7ffe00, 16'h0, `DEE_OP_PROG);
    wait_idle(n);
    rc(`DEE_OFS_ISTAT, 32'h2, "istat_err");
    rc(`DEE_OFS_CTRL, 32'h2001, "ctrl_err");
    wr(`DEE_OFS_IMASK, 32'h5);
    idle;
    check("irq_mask", irq, 32'h0);
    wr(`DEE_OFS_IMASK, 32'h2);
    idle;
    check("irq_unmask", irq, 32'h1);
    be <= 4'he;
    wr(`DEE_OFS_IMASK, 32'h0);
    be <= 4'hf;
    rc(`DEE_OFS_IMASK, 32'h2, "imask_lane");
    wr(`DEE_OFS_ISTAT, 32'h2);
    run(32'h7fff00, 16'hc3c3, `DEE_OP_PROG);
    wait_idle(n);
    rc(`DEE_OFS_DATA, 32'hc3c3, "data_small");
    variant <= `DEE_VAR_NONE;
    run(32'h7fff00, 16'h0, `DEE_OP_ERASE);
    wait_idle(n);
    rc(`DEE_OFS_ISTAT, 32'h3, "istat_none");
    $display("variant test done");
    tally_and_finish;
  end
endmodule // dee_ctrl_test
`default_nettype wire
